// [shared/ubg_defs.svh]
// Register offsets, field positions, reset values and divide counts of the baud generator.
`ifndef UBG_DEFS_SVH
`define UBG_DEFS_SVH

`define UBG_OFS_SERIAL_MODE 5'h00
`define UBG_OFS_POWER_CTRL 5'h04
`define UBG_OFS_TIMER_MODE 5'h08
`define UBG_OFS_T1_RELOAD 5'h0C
`define UBG_OFS_T2_CTRL 5'h10
`define UBG_OFS_T2_RELOAD_LOW 5'h14
`define UBG_OFS_T2_RELOAD_HIGH 5'h18
`define UBG_OFS_STATUS 5'h1C

`define UBG_BIT_DOUBLE 0
`define UBG_BIT_TX_T2 0
`define UBG_BIT_RX_T2 1
`define UBG_FLD_NIBBLE_LSB 4
`define UBG_FLD_NIBBLE_MSB 7

`define UBG_RST_MODE 2'h0
`define UBG_RST_BIT 1'h0
`define UBG_RST_NIBBLE 4'h0
`define UBG_RST_BYTE 8'h00
`define UBG_RST_WORD 32'h00000000

`define UBG_T1_AUTORELOAD_NIBBLE 4'h2
`define UBG_MC_LAST 4'hB
`define UBG_MODE2_LAST_SLOW 6'h3F
`define UBG_MODE2_LAST_FAST 6'h1F
`define UBG_T1_LAST_SLOW 5'h1F
`define UBG_T1_LAST_FAST 5'h0F
`define UBG_T1_TOP 8'hFF
`define UBG_T2_TOP 16'hFFFF
`define UBG_T2_LAST_OVF 4'hF

`define UBG_FRAME_BITS_SHIFT 4'h8
`define UBG_FRAME_BITS_8BIT 4'hA
`define UBG_FRAME_BITS_9BIT 4'hB

`endif

// [shared/ubg_pkg.sv]
// Types used by the baud generator top module.
package ubg_pkg;
  typedef enum logic [3:0] {
    UBG_MODE_SHIFT = 4'h1,
    UBG_MODE_VAR8 = 4'h2,
    UBG_MODE_FIX9 = 4'h4,
    UBG_MODE_VAR9 = 4'h8
  } ubg_mode_e;

  typedef enum logic [1:0] {
    UBG_BUS_IDLE = 2'h1,
    UBG_BUS_ACK = 2'h2
  } ubg_bus_e;
endpackage

// [shared/ubg_t2_if.sv]
// Carrier between the baud generator top and its Timer 2 rate generator.
`timescale 1ns/1ps
interface ubg_t2_if;
  logic enable;
  logic [15:0] reload;
  logic ovf;
  logic tick;
  logic [15:0] count;
  modport gen (input enable, input reload, output ovf, output tick, output count);
  modport user (output enable, output reload, input ovf, input tick, input count);
endinterface

// [rtl/ubg_timer2_gen.sv]
// Timer 2 in baud-generator mode: half-rate count, 16-bit auto-reload, divide by 16.
`timescale 1ns/1ps
`include "ubg_defs.svh"
module ubg_timer2_gen (
  input wire logic i_clock,
  input wire logic i_reset,
  ubg_t2_if.gen t2
);
  logic half_q;
  logic [15:0] count_q;
  logic [3:0] ovf_cnt_q;
  logic ovf_q;
  logic tick_q;
  logic ovf_now;

  always_ff @(posedge i_clock) begin
    if (i_reset || !t2.enable) begin
      half_q <= `UBG_RST_BIT;
    end else begin
      half_q <= ~half_q;
    end
  end

  assign ovf_now = t2.enable && half_q && (count_q == `UBG_T2_TOP);

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      count_q <= 16'h0000;
    end else if (!t2.enable) begin
      count_q <= t2.reload;
    end else if (half_q) begin
      if (ovf_now) begin
        count_q <= t2.reload;
      end else begin
        count_q <= count_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset || !t2.enable) begin
      ovf_cnt_q <= 4'h0;
      tick_q <= `UBG_RST_BIT;
      ovf_q <= `UBG_RST_BIT;
    end else begin
      ovf_q <= ovf_now;
      tick_q <= ovf_now && (ovf_cnt_q == `UBG_T2_LAST_OVF);
      if (ovf_now) begin
        ovf_cnt_q <= ovf_cnt_q + 4'h1;
      end
    end
  end

  assign t2.ovf = ovf_q;
  assign t2.tick = tick_q;
  assign t2.count = count_q;
endmodule

// [rtl/ubg_baud_gen.sv]
// Serial-port baud-rate generator with an Avalon-MM register slave.
`timescale 1ns/1ps
`include "ubg_defs.svh"
module ubg_baud_gen (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_timer1_overflow,
  output logic o_tx_bit_tick,
  output logic o_rx_bit_tick,
  output logic [1:0] o_serial_mode,
  output logic [3:0] o_frame_bits,
  output logic o_timer2_baud_mode
);
  logic [1:0] mode_q;
  logic double_q;
  logic [3:0] nibble_q;
  logic [7:0] t1_reload_q;
  logic tx_t2_q;
  logic rx_t2_q;
  logic [7:0] t2_low_q;
  logic [7:0] t2_high_q;
  ubg_pkg::ubg_bus_e bus_q;
  ubg_pkg::ubg_bus_e bus_d;
  ubg_pkg::ubg_mode_e mode_e;
  logic [31:0] readdata_q;
  logic [31:0] read_value;
  logic wr_en;
  logic [3:0] mc_cnt_q;
  logic mc_tick;
  logic t1_auto;
  logic [7:0] t1_cnt_q;
  logic t1_int_ovf;
  logic t1_ovf;
  logic [4:0] t1_div_q;
  logic [4:0] t1_last;
  logic t1_tick;
  logic [5:0] m2_cnt_q;
  logic [5:0] m2_last;
  logic m2_tick;
  logic tx_tick_d;
  logic rx_tick_d;
  logic tx_tick_q;
  logic rx_tick_q;
  logic [3:0] frame_bits_d;
  logic [3:0] frame_bits_q;
  logic [7:0] tx_tick_count_q;
  logic t2_mode_q;

  ubg_t2_if t2 ();

  ubg_timer2_gen u_timer2 (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .t2(t2)
  );

  // Bus handshake: each access is held one cycle, so the read word comes from a flop.
  always_comb begin
    case (bus_q)
      ubg_pkg::UBG_BUS_IDLE: begin
        if (i_avs_read || i_avs_write) begin
          bus_d = ubg_pkg::UBG_BUS_ACK;
        end else begin
          bus_d = ubg_pkg::UBG_BUS_IDLE;
        end
      end
      ubg_pkg::UBG_BUS_ACK: begin
        bus_d = ubg_pkg::UBG_BUS_IDLE;
      end
      default: begin
        bus_d = ubg_pkg::UBG_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      bus_q <= ubg_pkg::UBG_BUS_IDLE;
    end else begin
      bus_q <= bus_d;
    end
  end

  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && (bus_q != ubg_pkg::UBG_BUS_ACK);
  assign wr_en = i_avs_write && (bus_q == ubg_pkg::UBG_BUS_ACK);

  always_comb begin
    read_value = `UBG_RST_WORD;
    case (i_avs_address)
      `UBG_OFS_SERIAL_MODE: begin
        read_value = {30'h00000000, mode_q};
      end
      `UBG_OFS_POWER_CTRL: begin
        read_value = {31'h00000000, double_q};
      end
      `UBG_OFS_TIMER_MODE: begin
        read_value = {24'h000000, nibble_q, 4'h0};
      end
      `UBG_OFS_T1_RELOAD: begin
        read_value = {24'h000000, t1_reload_q};
      end
      `UBG_OFS_T2_CTRL: begin
        read_value = {30'h00000000, rx_t2_q, tx_t2_q};
      end
      `UBG_OFS_T2_RELOAD_LOW: begin
        read_value = {24'h000000, t2_low_q};
      end
      `UBG_OFS_T2_RELOAD_HIGH: begin
        read_value = {24'h000000, t2_high_q};
      end
      `UBG_OFS_STATUS: begin
        read_value = {t2.count, tx_tick_count_q, frame_bits_q, 1'h0, t1_auto, rx_t2_q,
                      t2_mode_q};
      end
      default: begin
        read_value = `UBG_RST_WORD;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      readdata_q <= `UBG_RST_WORD;
    end else if (i_avs_read && (bus_q == ubg_pkg::UBG_BUS_IDLE)) begin
      readdata_q <= read_value;
    end
  end

  assign o_avs_readdata = readdata_q;

  // Writes land only at the edge where waitrequest is low; unmapped writes are dropped.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      mode_q <= `UBG_RST_MODE;
      double_q <= `UBG_RST_BIT;
      nibble_q <= `UBG_RST_NIBBLE;
      t1_reload_q <= `UBG_RST_BYTE;
      tx_t2_q <= `UBG_RST_BIT;
      rx_t2_q <= `UBG_RST_BIT;
      t2_low_q <= `UBG_RST_BYTE;
      t2_high_q <= `UBG_RST_BYTE;
    end else if (wr_en) begin
      case (i_avs_address)
        `UBG_OFS_SERIAL_MODE: begin
          mode_q <= i_avs_writedata[1:0];
        end
        `UBG_OFS_POWER_CTRL: begin
          double_q <= i_avs_writedata[`UBG_BIT_DOUBLE];
        end
        `UBG_OFS_TIMER_MODE: begin
          nibble_q <= i_avs_writedata[`UBG_FLD_NIBBLE_MSB:`UBG_FLD_NIBBLE_LSB];
        end
        `UBG_OFS_T1_RELOAD: begin
          t1_reload_q <= i_avs_writedata[7:0];
        end
        `UBG_OFS_T2_CTRL: begin
          tx_t2_q <= i_avs_writedata[`UBG_BIT_TX_T2];
          rx_t2_q <= i_avs_writedata[`UBG_BIT_RX_T2];
        end
        `UBG_OFS_T2_RELOAD_LOW: begin
          t2_low_q <= i_avs_writedata[7:0];
        end
        `UBG_OFS_T2_RELOAD_HIGH: begin
          t2_high_q <= i_avs_writedata[7:0];
        end
        default: begin
          mode_q <= mode_q;
        end
      endcase
    end
  end

  always_comb begin
    case (mode_q)
      2'h0: mode_e = ubg_pkg::UBG_MODE_SHIFT;
      2'h1: mode_e = ubg_pkg::UBG_MODE_VAR8;
      2'h2: mode_e = ubg_pkg::UBG_MODE_FIX9;
      2'h3: mode_e = ubg_pkg::UBG_MODE_VAR9;
      default: mode_e = ubg_pkg::UBG_MODE_SHIFT;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset || mc_tick) begin
      mc_cnt_q <= 4'h0;
    end else begin
      mc_cnt_q <= mc_cnt_q + 4'h1;
    end
  end

  assign mc_tick = (mc_cnt_q == `UBG_MC_LAST);

  assign t1_auto = (nibble_q == `UBG_T1_AUTORELOAD_NIBBLE);
  assign t1_int_ovf = t1_auto && mc_tick && (t1_cnt_q == `UBG_T1_TOP);

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      t1_cnt_q <= `UBG_RST_BYTE;
    end else if (!t1_auto || t1_int_ovf) begin
      t1_cnt_q <= t1_reload_q;
    end else if (mc_tick) begin
      t1_cnt_q <= t1_cnt_q + 8'h01;
    end
  end

  // Other timer modes and counter use feed their overflow in.
  assign t1_ovf = t1_auto ? t1_int_ovf : i_timer1_overflow;

  // Divide Timer 1 overflows by 32, or 16 when doubled.
  assign t1_last = double_q ? `UBG_T1_LAST_FAST : `UBG_T1_LAST_SLOW;
  assign t1_tick = t1_ovf && (t1_div_q >= t1_last);

  // Comparing with >= keeps a mid-count change of the doubling bit from wrapping 32 overflows.
  always_ff @(posedge i_clock) begin
    if (i_reset || t1_tick) begin
      t1_div_q <= 5'h00;
    end else if (t1_ovf) begin
      t1_div_q <= t1_div_q + 5'h01;
    end
  end

  // Divide by 64, or 32 when doubled.
  assign m2_last = double_q ? `UBG_MODE2_LAST_FAST : `UBG_MODE2_LAST_SLOW;
  assign m2_tick = (m2_cnt_q >= m2_last);

  always_ff @(posedge i_clock) begin
    if (i_reset || m2_tick) begin
      m2_cnt_q <= 6'h00;
    end else begin
      m2_cnt_q <= m2_cnt_q + 6'h01;
    end
  end

  // Either select bit runs Timer 2 in baud mode.
  assign t2.enable = tx_t2_q || rx_t2_q;
  // Reload word from the two bytes.
  assign t2.reload = {t2_high_q, t2_low_q};

  always_comb begin
    tx_tick_d = 1'b0;
    rx_tick_d = 1'b0;
    case (mode_e)
      ubg_pkg::UBG_MODE_SHIFT: begin
        tx_tick_d = mc_tick;
        rx_tick_d = mc_tick;
      end
      ubg_pkg::UBG_MODE_FIX9: begin
        tx_tick_d = m2_tick;
        rx_tick_d = m2_tick;
      end
      ubg_pkg::UBG_MODE_VAR8, ubg_pkg::UBG_MODE_VAR9: begin
        // Per-direction Timer 2 or Timer 1.
        tx_tick_d = tx_t2_q ? t2.tick : t1_tick;
        rx_tick_d = rx_t2_q ? t2.tick : t1_tick;
      end
      default: begin
        tx_tick_d = 1'b0;
        rx_tick_d = 1'b0;
      end
    endcase
  end

  always_comb begin
    case (mode_e)
      ubg_pkg::UBG_MODE_SHIFT: frame_bits_d = `UBG_FRAME_BITS_SHIFT;
      ubg_pkg::UBG_MODE_VAR8: frame_bits_d = `UBG_FRAME_BITS_8BIT;
      ubg_pkg::UBG_MODE_FIX9: frame_bits_d = `UBG_FRAME_BITS_9BIT;
      ubg_pkg::UBG_MODE_VAR9: frame_bits_d = `UBG_FRAME_BITS_9BIT;
      default: frame_bits_d = `UBG_FRAME_BITS_SHIFT;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      tx_tick_q <= `UBG_RST_BIT;
      rx_tick_q <= `UBG_RST_BIT;
      frame_bits_q <= `UBG_FRAME_BITS_SHIFT;
      t2_mode_q <= `UBG_RST_BIT;
    end else begin
      tx_tick_q <= tx_tick_d;
      rx_tick_q <= rx_tick_d;
      frame_bits_q <= frame_bits_d;
      t2_mode_q <= t2.enable;
    end
  end

  // The tick count wraps freely; software uses it only to see that the rate is alive.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      tx_tick_count_q <= `UBG_RST_BYTE;
    end else if (tx_tick_q) begin
      tx_tick_count_q <= tx_tick_count_q + 8'h01;
    end
  end

  assign o_tx_bit_tick = tx_tick_q;
  assign o_rx_bit_tick = rx_tick_q;
  assign o_serial_mode = mode_q;
  assign o_frame_bits = frame_bits_q;
  assign o_timer2_baud_mode = t2_mode_q;
endmodule

// [testbench/ubg_baud_checker.sv]
// Port-level checks on the baud generator, bound into its top module.
`timescale 1ns/1ps
module ubg_baud_checker (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic o_tx_bit_tick,
  input wire logic o_rx_bit_tick,
  input wire logic [1:0] o_serial_mode,
  input wire logic [3:0] o_frame_bits,
  input wire logic o_timer2_baud_mode
);
  logic [1:0] mode_q;
  logic dbl_q;
  logic [1:0] sel_q;
  logic [7:0] age_q;
  logic wr_done;
  assign wr_done = i_avs_write & ~o_avs_waitrequest;
  // Shadow copies let the checks know the settings; age_q masks the early first tick.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      mode_q <= 2'h0;
      dbl_q <= 1'h0;
      sel_q <= 2'h0;
      age_q <= 8'h00;
    end else begin
      age_q <= wr_done ? 8'h00 : age_q + {7'h00, age_q != 8'hFF};
      if (wr_done && i_avs_address == 5'h00) mode_q <= i_avs_writedata[1:0];
      if (wr_done && i_avs_address == 5'h04) dbl_q <= i_avs_writedata[0];
      if (wr_done && i_avs_address == 5'h10) sel_q <= i_avs_writedata[1:0];
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  sequence s_ack;
    o_avs_waitrequest ##1 !o_avs_waitrequest;
  endsequence
  sequence s_settled;
    age_q >= 8'h02;
  endsequence
  property p_wait_one;
    $rose(i_avs_read || i_avs_write) |-> s_ack;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait state count wrong");
  property p_idle;
    !(i_avs_read || i_avs_write) |-> !o_avs_waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("waitrequest high when idle");
  property p_unmapped;
    i_avs_read && !o_avs_waitrequest && i_avs_address[1:0] != 2'h0 |-> o_avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_mode_out;
    s_settled |-> o_serial_mode == mode_q;
  endproperty
  a_mode_out: assert property (p_mode_out) else $error("serial mode output wrong");
  property p_frame;
    s_settled |-> o_frame_bits == (mode_q == 2'h0 ? 4'h8 : mode_q == 2'h1 ? 4'hA : 4'hB);
  endproperty
  a_frame: assert property (p_frame) else $error("frame bit count wrong");
  property p_t2_mode;
    s_settled |-> o_timer2_baud_mode == (|sel_q);
  endproperty
  a_t2_mode: assert property (p_t2_mode) else $error("timer 2 mode flag wrong");
  property p_mode0;
    age_q >= 8'h1E && mode_q == 2'h0 && o_tx_bit_tick |-> ##12 (o_tx_bit_tick || age_q < 8'h0C);
  endproperty
  a_mode0: assert property (p_mode0) else $error("shift mode period wrong");
  property p_fix_slow;
    age_q >= 8'h96 && mode_q == 2'h2 && !dbl_q && o_tx_bit_tick
      |-> ##64 (o_tx_bit_tick || age_q < 8'h40);
  endproperty
  a_fix_slow: assert property (p_fix_slow) else $error("fixed mode slow period wrong");
  property p_fix_fast;
    age_q >= 8'h96 && mode_q == 2'h2 && dbl_q && o_tx_bit_tick
      |-> ##32 (o_tx_bit_tick || age_q < 8'h20);
  endproperty
  a_fix_fast: assert property (p_fix_fast) else $error("fixed mode fast period wrong");
endmodule
bind ubg_baud_gen ubg_baud_checker u_chk (.i_clock(i_clock), .i_reset(i_reset),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_tx_bit_tick(o_tx_bit_tick),
  .o_rx_bit_tick(o_rx_bit_tick), .o_serial_mode(o_serial_mode),
  .o_frame_bits(o_frame_bits), .o_timer2_baud_mode(o_timer2_baud_mode));

// [testbench/ubg_t1_model.sv]
// External Timer 1 model that emits overflow pulses at a set spacing.
`timescale 1ns/1ps
module ubg_t1_model (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [7:0] i_period,
  output logic o_overflow
);
  logic [7:0] cnt_q;
  always_ff @(posedge i_clock) begin
    if (i_reset || cnt_q >= i_period - 8'h01) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  assign o_overflow = !i_reset && cnt_q == i_period - 8'h01;
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the baud generator.
`timescale 1ns/1ps
module tb_top;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic [4:0] i_avs_address = 5'h00;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h00000000;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest, o_tx_bit_tick, o_rx_bit_tick, o_timer2_baud_mode, t1_ovf;
  logic [1:0] o_serial_mode;
  logic [3:0] o_frame_bits;
  logic [7:0] t1_period = 8'h04;
  logic [7:0] lfsr_q = 8'h14;
  logic [7:0] rl;
  logic [4:0] a;
  logic [31:0] q;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int n, p, rt;
  ubg_baud_gen DUT (.i_clock(i_clock), .i_reset(i_reset), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_timer1_overflow(t1_ovf), .o_tx_bit_tick(o_tx_bit_tick), .o_rx_bit_tick(o_rx_bit_tick),
    .o_serial_mode(o_serial_mode), .o_frame_bits(o_frame_bits),
    .o_timer2_baud_mode(o_timer2_baud_mode));
  ubg_t1_model u_t1 (.i_clock(i_clock), .i_reset(i_reset), .i_period(t1_period),
    .o_overflow(t1_ovf));
  initial forever #5 i_clock = ~i_clock;
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_count++;
      wrap_up();
    end
  end
  function logic [7:0] rnd(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function int per(int m, int d, int t1);
    return m == 0 ? 12 : m == 2 ? (d ? 32 : 64) : t1 * (d ? 16 : 32);
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is sampled low; only the run timeout ends a stuck wait.
  task bus(input logic wr, input logic [4:0] ad, input logic [31:0] d);
    @(posedge i_clock);
    i_avs_address <= ad;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    i_avs_writedata <= d;
    do begin
      @(posedge i_clock);
    end while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask
  task rd(input logic [4:0] ad, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, ad, 32'h00000000);
    chk(q & m, e);
  endtask
  // The first two gaps after a change may be short, so the third is judged.
  task gap(input logic rx, input int e);
    repeat (3) begin
      n = 0;
      do begin
        @(posedge i_clock);
        n++;
      end while ((rx ? o_rx_bit_tick : o_tx_bit_tick) !== 1'b1 && n < 3000);
    end
    chk(n, e);
  endtask
  initial begin
    repeat (10) @(posedge i_clock);
    i_reset <= 1'b0;
    for (a = 5'h00; a < 5'h1C; a += 5'h04) rd(a, 32'hFFFFFFFF, 32'h0);
    rd(5'h1C, 32'hFF, 32'h80);
    // Two status captures exactly 120 clocks apart see ten shift-mode ticks, whatever the phase.
    rl = q[15:8];
    repeat (117) @(posedge i_clock);
    bus(1'b0, 5'h1C, 32'h0);
    chk(8'(q[15:8] - rl), 32'hA);
    bus(1'b1, 5'h02, 32'h3);
    rd(5'h02, 32'hFFFFFFFF, 32'h0);
    rd(5'h00, 32'hFFFFFFFF, 32'h0);
    lfsr_q = rnd(lfsr_q);
    rl = 8'hFC | (lfsr_q & 8'h03);
    bus(1'b1, 5'h08, 32'h20);
    bus(1'b1, 5'h0C, {24'h0, rl});
    for (int m = 0; m < 4; m++) begin
      for (int d = 0; d < 2; d++) begin
        bus(1'b1, 5'h00, 32'(m));
        bus(1'b1, 5'h04, 32'(d));
        rd(5'h00, 32'h3, 32'(m));
        rd(5'h1C, 32'hF4, m == 0 ? 32'h84 : m == 1 ? 32'hA4 : 32'hB4);
        gap(1'b0, per(m, d, 12 * (256 - rl)));
        gap(1'b1, per(m, d, 12 * (256 - rl)));
      end
    end
    lfsr_q = rnd(lfsr_q);
    p = 2 + (lfsr_q & 7);
    t1_period <= 8'(p);
    bus(1'b1, 5'h08, {24'h0, lfsr_q[7:4] == 4'h2 ? 4'h6 : lfsr_q[7:4], 4'h0});
    rd(5'h1C, 32'h4, 32'h0);
    for (int d = 0; d < 2; d++) begin
      bus(1'b1, 5'h04, 32'(d));
      gap(1'b0, per(3, d, p));
    end
    lfsr_q = rnd(lfsr_q);
    rt = 32'hFF00 | 32'hF0 | lfsr_q;
    bus(1'b1, 5'h14, {24'h0, 8'hF0 | lfsr_q});
    bus(1'b1, 5'h18, 32'hFF);
    for (int s = 1; s < 3; s++) begin
      bus(1'b1, 5'h10, 32'(s));
      rd(5'h1C, 32'h3, s == 1 ? 32'h1 : 32'h3);
      for (int d = 0; d < 2; d++) begin
        bus(1'b1, 5'h04, 32'(d));
        gap(s == 2, 32 * (65536 - rt));
        gap(s == 1, per(3, d, p));
      end
    end
    bus(1'b1, 5'h10, 32'h0);
    rd(5'h1C, 32'h3, 32'h0);
    rd(5'h1C, 32'hFFFF0000, 32'(rt) << 16);
    wrap_up();
  end
endmodule
